// ===== include/csm_params.svh
`ifndef CSM_PARAMS_SVH
`define CSM_PARAMS_SVH
`define CSM_BIT_NEG 31
`define CSM_BIT_ZERO 30
`define CSM_BIT_CARRY 29
`define CSM_BIT_OVF 28
`define CSM_BIT_TSTATE 24
`define CSM_EXC_MSB 5
`define CSM_EXC_THREAD 6'h00
`define CSM_EXC_NMI 6'h02
`define CSM_EXC_FAULT 6'h03
`define CSM_EXC_SVC 6'h0b
`define CSM_EXC_PENDSVC 6'h0e
`define CSM_EXC_TICK 6'h0f
`define CSM_EXC_IRQ_BASE 6'h10
`define CSM_EXC_IRQ_LAST 6'h2f
`define CSM_VEC_SP 32'h00000000
`define CSM_VEC_PC 32'h00000004
`define CSM_CTRL_SPSEL 1
`define CSM_TICK_W 24
`define CSM_TICK_RESET 24'h000000
`define CSM_PSR_MASK 32'hf100003f
`endif

// ===== include/csm_pkg.sv
package csm_pkg;
  typedef enum logic [3:0] {
    CSM_BOOT_SP = 4'b0001,
    CSM_BOOT_PC = 4'b0010,
    CSM_RUN = 4'b0100,
    CSM_HALT = 4'b1000
  } csm_boot_t;
  typedef enum logic [1:0] {
    CSM_SZ_BYTE = 2'h0,
    CSM_SZ_HALF = 2'h1,
    CSM_SZ_WORD = 2'h2,
    CSM_SZ_MULTI = 2'h3
  } csm_size_t;
  typedef enum logic [1:0] {
    CSM_SR_PSR = 2'h0,
    CSM_SR_GATE = 2'h1,
    CSM_SR_CTRL = 2'h2,
    CSM_SR_RELOAD = 2'h3
  } csm_sreg_t;
endpackage

// ===== hw/csm_core_state.sv
// Summary of operation
// RULE_01: flags n z c v at bits 31..28
// RULE_02: flag-setting ops write flags, plain ops don't
// RULE_03: execution with state bit zero faults
// RULE_04: bits 5..0 show active exception number
// RULE_05: gate set blocks configurable-priority exceptions
// RULE_06: special write and state change drive gate
// RULE_07: thread mode stack from control bit 1
// RULE_08: handler mode always uses main stack
// RULE_09: handler mode ignores software control writes
// RULE_10: exception entry/return update control automatically; the code holds spsel_q through both and only reloads spsel_live_q
// RULE_11: after barrier new stack selection is used
// RULE_12: aligned by access size, bytes always aligned
// RULE_13: unaligned access raises severe fault
// RULE_14: little-endian byte lanes
// RULE_15: tick timer has 24-bit reload value
// RULE_16: tick runs on core clock, irq to controller
// RULE_17: pc and sp operand use restricted
// RULE_18: reset loads main stack from word 0
// RULE_19: reset loads pc, state bit from word 4
// RULE_20: tick at zero reloads and requests irq
// RULE_21: reserved status bits read zero
`include "csm_params.svh"
`timescale 1ns/10ps
`default_nettype none
module csm_core_state
  import csm_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  output logic vec_req_out,
  output logic [31:0] vec_addr_out,
  input wire logic vec_valid_in,
  input wire logic [31:0] vec_data_in,
  output logic [31:0] pc_out,
  output logic boot_done_out,
  input wire logic flag_upd_in,
  input wire logic flag_set_op_in,
  input wire logic [3:0] flags_in,
  input wire logic sreg_wr_in,
  input wire logic [1:0] sreg_sel_in,
  input wire logic [31:0] sreg_wdata_in,
  output logic [31:0] sreg_rdata_out,
  input wire logic state_chg_in,
  input wire logic state_chg_disable_in,
  input wire logic barrier_in,
  input wire logic exc_enter_in,
  input wire logic [5:0] exc_num_in,
  input wire logic exc_return_in,
  input wire logic [5:0] exc_ret_num_in,
  input wire logic [4:0] irq_line_in,
  input wire logic irq_pend_in,
  output logic irq_take_out,
  input wire logic nmi_pend_in,
  input wire logic exec_in,
  input wire logic pcsp_misuse_in,
  input wire logic mem_req_in,
  input wire logic [1:0] mem_size_in,
  input wire logic [31:0] mem_addr_in,
  input wire logic [31:0] mem_wdata_in,
  output logic mem_go_out,
  output logic [3:0] mem_be_out,
  output logic [31:0] mem_lane_data_out,
  output logic fault_out,
  output logic use_process_sp_out,
  output logic [31:0] main_stack_pointer_out,
  output logic [31:0] process_stack_pointer_out,
  input wire logic sp_wr_in,
  input wire logic [31:0] sp_wdata_in,
  output logic tick_irq_out,
  output logic [23:0] tick_count_out
);
  // ==========================================================
  // reset vector fetch
  csm_boot_t boot_q;
  csm_boot_t boot_d;
  logic [31:0] pc_q;
  // vectors are taken in order, one per valid strobe
  always_comb begin
    boot_d = boot_q;
    case (boot_q)
      CSM_BOOT_SP: if (vec_valid_in) boot_d = CSM_BOOT_PC;
      CSM_BOOT_PC: if (vec_valid_in) boot_d = CSM_RUN;
      CSM_RUN: boot_d = CSM_RUN;
      CSM_HALT: boot_d = CSM_HALT;
      default: boot_d = CSM_BOOT_SP;
    endcase
  end
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      boot_q <= CSM_BOOT_SP;
    end else begin
      boot_q <= boot_d;
    end
  end
  assign vec_req_out = (boot_q == CSM_BOOT_SP) || (boot_q == CSM_BOOT_PC);
  assign vec_addr_out = (boot_q == CSM_BOOT_PC) ? `CSM_VEC_PC : `CSM_VEC_SP; // RULE_18 RULE_19
  assign boot_done_out = (boot_q == CSM_RUN);
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pc_q <= 32'h00000000;
    end else if (boot_q == CSM_BOOT_PC && vec_valid_in) begin
      pc_q <= {vec_data_in[31:1], 1'b0}; // RULE_19
    end
  end
  assign pc_out = pc_q;

  // ==========================================================
  // status word
  logic [3:0] flags_q;
  logic tstate_q;
  logic [5:0] exc_q;
  logic handler_mode;
  logic psr_wr;
  assign handler_mode = (exc_q != `CSM_EXC_THREAD);
  assign psr_wr = sreg_wr_in && (sreg_sel_in == CSM_SR_PSR);
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      flags_q <= 4'h0;
    end else if (flag_upd_in && flag_set_op_in) begin
      flags_q <= flags_in; // RULE_02
    end else if (psr_wr) begin
      flags_q <= sreg_wdata_in[`CSM_BIT_NEG:`CSM_BIT_OVF]; // RULE_01
    end
  end
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      tstate_q <= 1'b0;
    end else if (boot_q == CSM_BOOT_PC && vec_valid_in) begin
      tstate_q <= vec_data_in[0]; // RULE_19
    end
  end
  // a fault outranks any entry or return in the same cycle
  logic [5:0] exc_d;
  always_comb begin
    exc_d = exc_q;
    if (fault_out) begin
      exc_d = `CSM_EXC_FAULT; // RULE_04
    end else if (exc_enter_in) begin
      exc_d = exc_num_in; // RULE_04
    end else if (exc_return_in) begin
      exc_d = exc_ret_num_in; // RULE_04
    end
  end
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      exc_q <= `CSM_EXC_THREAD;
    end else begin
      exc_q <= exc_d;
    end
  end

  // ==========================================================
  // exception gate
  logic gate_q;
  logic gate_d;
  // state change beats a register write in the same cycle
  always_comb begin
    gate_d = gate_q;
    if (state_chg_in) begin
      gate_d = state_chg_disable_in; // RULE_06
    end else if (sreg_wr_in && sreg_sel_in == CSM_SR_GATE) begin
      gate_d = sreg_wdata_in[0]; // RULE_06
    end
  end
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= gate_d;
    end
  end
  // nmi and fault bypass the gate
  assign irq_take_out = boot_done_out && !nmi_pend_in && !fault_out &&
                        (tick_irq_out || irq_pend_in) && !gate_q; // RULE_05

  // ==========================================================
  // control and stacks
  logic spsel_q;
  logic spsel_d;
  logic spsel_live_q;
  logic [31:0] msp_q;
  logic [31:0] psp_q;
  logic [31:0] sp_aligned;
  // entry and return own the bit; a software write that cycle is lost
  always_comb begin
    spsel_d = spsel_q;
    if (exc_return_in && exc_ret_num_in == `CSM_EXC_THREAD) begin
      spsel_d = spsel_q; // RULE_10
    end else if (exc_enter_in && !handler_mode) begin
      spsel_d = spsel_q; // RULE_10
    end else if (sreg_wr_in && sreg_sel_in == CSM_SR_CTRL && !handler_mode) begin
      spsel_d = sreg_wdata_in[`CSM_CTRL_SPSEL]; // RULE_07 RULE_09
    end
  end
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      spsel_q <= 1'b0;
    end else begin
      spsel_q <= spsel_d;
    end
  end
  // stack pointer writes are forced word aligned; the boot load of the main stack is taken as is
  assign sp_aligned = {sp_wdata_in[31:2], 2'b00};
  // selection reaches the stack mux at the barrier or mode change
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      spsel_live_q <= 1'b0;
    end else if (barrier_in || exc_enter_in || exc_return_in) begin
      spsel_live_q <= spsel_q; // RULE_11 RULE_10
    end
  end
  assign use_process_sp_out = spsel_live_q && !handler_mode; // RULE_07 RULE_08
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      msp_q <= 32'h00000000;
    end else if (boot_q == CSM_BOOT_SP && vec_valid_in) begin
      msp_q <= vec_data_in; // RULE_18
    end else if (sp_wr_in && !use_process_sp_out) begin
      msp_q <= sp_aligned;
    end
  end
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      psp_q <= 32'h00000000;
    end else if (sp_wr_in && use_process_sp_out) begin
      psp_q <= sp_aligned;
    end
  end
  assign main_stack_pointer_out = msp_q;
  assign process_stack_pointer_out = psp_q;

  // ==========================================================
  // alignment and byte lanes
  logic aligned;
  always_comb begin
    case (csm_size_t'(mem_size_in))
      CSM_SZ_BYTE: aligned = 1'b1; // RULE_12
      CSM_SZ_HALF: aligned = !mem_addr_in[0]; // RULE_12
      default: aligned = (mem_addr_in[1:0] == 2'b00); // RULE_12
    endcase
  end
  assign mem_go_out = mem_req_in && aligned && boot_done_out; // RULE_13
  logic [3:0] be_d;
  logic [31:0] lane_d;
  // narrow data is replicated so every enabled lane carries it
  always_comb begin
    be_d = 4'hf;
    lane_d = mem_wdata_in;
    case (csm_size_t'(mem_size_in))
      CSM_SZ_BYTE: begin
        be_d = 4'h1 << mem_addr_in[1:0]; // RULE_14
        lane_d = {4{mem_wdata_in[7:0]}};
      end
      CSM_SZ_HALF: begin
        be_d = mem_addr_in[1] ? 4'hc : 4'h3; // RULE_14
        lane_d = {2{mem_wdata_in[15:0]}};
      end
      default: begin
        be_d = 4'hf;
        lane_d = mem_wdata_in;
      end
    endcase
  end
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      mem_be_out <= 4'h0;
      mem_lane_data_out <= 32'h00000000;
    end else if (mem_go_out) begin
      mem_be_out <= be_d;
      mem_lane_data_out <= lane_d;
    end
  end

  // ==========================================================
  // severe fault
  logic fault_q;
  logic fault_tstate;
  logic fault_align;
  logic fault_misuse;
  // nothing faults before both vectors are in
  assign fault_tstate = exec_in && boot_done_out && !tstate_q; // RULE_03
  assign fault_align = mem_req_in && !aligned && boot_done_out; // RULE_13
  assign fault_misuse = exec_in && pcsp_misuse_in && boot_done_out; // RULE_17
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_tstate || fault_align || fault_misuse;
    end
  end
  assign fault_out = fault_q;

  // ==========================================================
  // tick timer
  logic [23:0] reload_q;
  logic [23:0] tick_q;
  logic tick_irq_q;
  logic [23:0] tick_d;
  logic tick_irq_d;
  always_comb begin
    tick_d = tick_q - 24'h000001; // RULE_16
    tick_irq_d = 1'b0;
    if (tick_q == 24'h000000) begin
      tick_d = reload_q; // RULE_20
      // a zero reload parks the counter without requests
      tick_irq_d = (reload_q != 24'h000000); // RULE_20
    end
  end
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      reload_q <= `CSM_TICK_RESET;
    end else if (sreg_wr_in && sreg_sel_in == CSM_SR_RELOAD) begin
      reload_q <= sreg_wdata_in[`CSM_TICK_W-1:0]; // RULE_15
    end
  end
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      tick_q <= `CSM_TICK_RESET;
      tick_irq_q <= 1'b0;
    end else begin
      tick_q <= tick_d;
      tick_irq_q <= tick_irq_d;
    end
  end
  assign tick_irq_out = tick_irq_q; // RULE_20
  assign tick_count_out = tick_q;

  // ==========================================================
  // special register read
  always_comb begin
    case (csm_sreg_t'(sreg_sel_in))
      CSM_SR_PSR: sreg_rdata_out = {flags_q, 3'b000, tstate_q, 18'h00000, exc_q} & `CSM_PSR_MASK; // RULE_21
      CSM_SR_GATE: sreg_rdata_out = {31'h00000000, gate_q};
      CSM_SR_CTRL: sreg_rdata_out = {30'h00000000, spsel_q, 1'b0};
      default: sreg_rdata_out = {8'h00, reload_q};
    endcase
  end
endmodule
`default_nettype wire

// ===== verification/csm_vec_mem.sv
`timescale 1ns/10ps
`default_nettype none
module csm_vec_mem #(
  parameter logic [31:0] SP_W = 32'h20000ff0,
  parameter logic [31:0] PC_W = 32'h00000101
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic req_in,
  input wire logic [31:0] addr_in,
  output logic valid_out,
  output logic [31:0] data_out
);
  // answers every other cycle, data churns while idle
  always_ff @(posedge clk_in) begin
    valid_out <= !reset_in && req_in && !valid_out;
    data_out <= reset_in ? 32'h0f0f0f0f : (valid_out || !req_in) ? ~data_out : addr_in[2] ? PC_W : SP_W;
  end
endmodule
`default_nettype wire

// ===== verification/csm_core_state_chk.sv
`timescale 1ns/10ps
`default_nettype none
module csm_core_state_chk (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic boot_done_out,
  input wire logic mem_req_in,
  input wire logic [1:0] mem_size_in,
  input wire logic [31:0] mem_addr_in,
  input wire logic mem_go_out,
  input wire logic [3:0] mem_be_out,
  input wire logic fault_out,
  input wire logic [1:0] sreg_sel_in,
  input wire logic [31:0] sreg_rdata_out,
  input wire logic use_process_sp_out,
  input wire logic irq_pend_in,
  input wire logic irq_take_out,
  input wire logic tick_irq_out,
  input wire logic [23:0] tick_count_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence byte_s;
    mem_req_in && boot_done_out && mem_size_in == 2'h0;
  endsequence
  sequence unal_s;
    mem_req_in && boot_done_out && (mem_size_in[1] ? mem_addr_in[1:0] != 2'h0 : mem_size_in[0] && mem_addr_in[0]);
  endsequence
  unal_fault_a: assert property (unal_s |-> !mem_go_out ##1 fault_out)
    else $error("unaligned not faulted");
  byte_go_a: assert property (byte_s |-> mem_go_out)
    else $error("byte refused");
  byte_lane_a: assert property (byte_s |=> mem_be_out == 4'h1 << $past(mem_addr_in[1:0]))
    else $error("byte lane wrong");
  psr_resv_a: assert property (sreg_sel_in == 2'h0 |-> (sreg_rdata_out & 32'h0effffc0) == 32'h0)
    else $error("reserved bits set");
  handler_msp_a: assert property (sreg_sel_in == 2'h0 && sreg_rdata_out[5:0] != 6'h0 |-> !use_process_sp_out)
    else $error("process stack in handler");
  gate_pend_a: assert property (irq_take_out |-> irq_pend_in || tick_irq_out)
    else $error("irq taken unpended");
  gate_block_a: assert property (sreg_sel_in == 2'h1 && sreg_rdata_out[0] |-> !irq_take_out)
    else $error("irq taken while gated");
  tick_down_a: assert property (tick_count_out != 24'h0 |=> tick_count_out == $past(tick_count_out) - 24'h1)
    else $error("tick skipped");
  tick_irq_a: assert property (tick_irq_out |-> $past(tick_count_out) == 24'h0 && tick_count_out != 24'h0)
    else $error("tick irq off reload");
endmodule
bind csm_core_state csm_core_state_chk chk_i (.*);
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_in, reset_in, vec_req_out, vec_valid_in, boot_done_out, flag_upd_in, flag_set_op_in, sreg_wr_in;
  logic state_chg_in, state_chg_disable_in, barrier_in, exc_enter_in, exc_return_in, irq_pend_in, irq_take_out;
  logic nmi_pend_in, exec_in, pcsp_misuse_in, mem_req_in, mem_go_out, fault_out, use_process_sp_out;
  logic sp_wr_in, tick_irq_out;
  logic [1:0] sreg_sel_in, mem_size_in;
  logic [3:0] flags_in, mem_be_out, flag_q, be_exp;
  logic [4:0] irq_line_in;
  logic [5:0] exc_num_in, exc_ret_num_in;
  logic [5:0] codes [7] = '{6'h02, 6'h03, 6'h0b, 6'h0e, 6'h0f, 6'h10, 6'h2f};
  logic [15:0] lfsr_q;
  logic [23:0] tick_count_out;
  logic [31:0] vec_addr_out, vec_data_in, pc_out, sreg_wdata_in, sreg_rdata_out, mem_addr_in, mem_wdata_in;
  logic [31:0] mem_lane_data_out, main_stack_pointer_out, process_stack_pointer_out, sp_wdata_in;
  int num_errors, samples_checked, n;
  csm_core_state dut (.*);
  csm_vec_mem mem_i (.clk_in, .reset_in, .req_in(vec_req_out), .addr_in(vec_addr_out), .valid_out(vec_valid_in),
    .data_out(vec_data_in));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic sreg_put(input logic [1:0] sel, input logic [31:0] d);
    sreg_sel_in = sel;
    sreg_wdata_in = d;
    sreg_wr_in = 1;
    @(negedge clk_in);
    sreg_wr_in = 0;
  endtask
  task automatic sreg_chk(input string what, input logic [1:0] sel, input logic [31:0] e);
    sreg_sel_in = sel;
    #1;
    chk(what, e, sreg_rdata_out);
  endtask
  task automatic exc(input logic ent, input logic [5:0] num);
    exc_enter_in = ent;
    exc_return_in = !ent;
    exc_num_in = num;
    exc_ret_num_in = num;
    @(negedge clk_in);
    exc_enter_in = 0;
    exc_return_in = 0;
  endtask
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // expected byte enables, zero when unaligned
  function automatic logic [3:0] lanes(input logic [1:0] s, input logic [1:0] a);
    if (s == 2'h0) return 4'h1 << a;
    if (s == 2'h1) return a[0] ? 4'h0 : a[1] ? 4'hc : 4'h3;
    return a == 2'h0 ? 4'hf : 4'h0;
  endfunction
  function automatic logic [31:0] lane_data(input logic [1:0] s, input logic [31:0] d);
    if (s == 2'h0) return {4{d[7:0]}};
    if (s == 2'h1) return {2{d[15:0]}};
    return d;
  endfunction
  initial begin
    clk_in = 0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    {flag_upd_in, flag_set_op_in, sreg_wr_in, state_chg_in, state_chg_disable_in, barrier_in, exc_enter_in} = '0;
    {exc_return_in, irq_pend_in, nmi_pend_in, exec_in, pcsp_misuse_in, mem_req_in, sp_wr_in, irq_line_in} = '0;
    {sreg_sel_in, mem_size_in, flags_in, exc_num_in, exc_ret_num_in, sreg_wdata_in, mem_addr_in} = '0;
    {mem_wdata_in, sp_wdata_in, flag_q} = '0;
    lfsr_q = 16'h64e9;
    reset_in = 1;
    repeat (3) @(negedge clk_in);
    reset_in = 0;
    for (n = 0; n < 9 && boot_done_out !== 1'b1; n++) @(negedge clk_in);
    chk("msp", 32'h20000ff0, main_stack_pointer_out);
    chk("pc", 32'h00000100, pc_out);
    sreg_chk("psr", 2'h0, 32'h01000000);
    $display("boot done");
    for (int i = 0; i < 12; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      flags_in = lfsr_q[3:0];
      flag_set_op_in = lfsr_q[4];
      flag_upd_in = 1;
      @(negedge clk_in);
      flag_upd_in = 0;
      if (flag_set_op_in) flag_q = flags_in;
      sreg_chk("flags", 2'h0, {flag_q, 28'h1000000});
    end
    irq_pend_in = 1;
    sreg_put(2'h1, 32'h1);
    chk("gated", 0, irq_take_out);
    state_chg_in = 1;
    @(negedge clk_in);
    state_chg_in = 0;
    chk("opened", 1, irq_take_out);
    state_chg_in = 1;
    state_chg_disable_in = 1;
    @(negedge clk_in);
    {state_chg_in, state_chg_disable_in} = '0;
    chk("state gated", 0, irq_take_out);
    sreg_chk("gate read", 2'h1, 32'h1);
    sreg_put(2'h1, 32'h0);
    irq_pend_in = 0;
    sreg_put(2'h2, 32'h2);
    chk("pre barrier", 0, use_process_sp_out);
    barrier_in = 1;
    @(negedge clk_in);
    barrier_in = 0;
    chk("psp used", 1, use_process_sp_out);
    sp_wdata_in = {lfsr_q, lfsr_q};
    sp_wr_in = 1;
    @(negedge clk_in);
    sp_wr_in = 0;
    chk("psp", {lfsr_q, lfsr_q[15:2], 2'h0}, process_stack_pointer_out);
    for (int i = 0; i < 7; i++) begin
      exc(1, codes[i]);
      sreg_chk("exc", 2'h0, {flag_q, 4'h1, 18'h0, codes[i]});
      chk("handler msp", 0, use_process_sp_out);
      if (i == 0) begin
        sreg_put(2'h2, 32'h0);
        sreg_chk("ctrl kept", 2'h2, 32'h2);
        sreg_sel_in = 2'h0;
      end
      exc(0, 6'h00);
      chk("thread psp", 1, use_process_sp_out);
    end
    sreg_chk("thread", 2'h0, {flag_q, 28'h1000000});
    $display("modes done");
    for (int i = 0; i < 30; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      mem_size_in = i < 3 ? 2'(i + 1) : lfsr_q[9:8];
      mem_addr_in = i < 3 ? 32'h20000002 : {16'h2000, lfsr_q};
      mem_wdata_in = {lfsr_q, ~lfsr_q};
      be_exp = lanes(mem_size_in, mem_addr_in[1:0]);
      mem_req_in = 1;
      #1;
      chk("go", be_exp != 4'h0, mem_go_out);
      @(negedge clk_in);
      mem_req_in = 0;
      chk("fault", be_exp == 4'h0, fault_out);
      if (be_exp != 4'h0) chk("lanes", be_exp, mem_be_out);
      if (be_exp != 4'h0) chk("lane data", lane_data(mem_size_in, mem_wdata_in), mem_lane_data_out);
      else begin
        @(negedge clk_in);
        chk("align exc", 6'h03, sreg_rdata_out[5:0]);
        exc(0, 6'h00);
      end
    end
    $display("align done");
    exec_in = 1;
    pcsp_misuse_in = 1;
    @(negedge clk_in);
    {exec_in, pcsp_misuse_in} = '0;
    chk("misuse fault", 1, fault_out);
    @(negedge clk_in);
    chk("fault exc", 6'h03, sreg_rdata_out[5:0]);
    exc(0, 6'h00);
    exec_in = 1;
    @(negedge clk_in);
    exec_in = 0;
    chk("exec ok", 0, fault_out);
    $display("exec done");
    sreg_put(2'h3, 32'hff000005);
    sreg_chk("reload", 2'h3, 32'h5);
    for (n = 0; n < 20 && tick_irq_out !== 1'b1; n++) @(negedge clk_in);
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (n < 20 && tick_irq_out !== 1'b1);
    chk("tick period", 6, n);
    $display("tick done");
    report_and_stop();
  end
endmodule
`default_nettype wire
